// >>> hdl/gate_pkg.sv
package gate_pkg;

  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned TICK_HZ       = 1_000;
  localparam int unsigned TICK_DIV      = CLK_HZ / TICK_HZ;
  localparam int unsigned PREWARN_MS    = 5_000;
  localparam int unsigned PREWARN_TICKS = PREWARN_MS * TICK_HZ / 1_000;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam int unsigned BLINK_TICKS   = BLINK_HALF_MS * TICK_HZ / 1_000;

  localparam int unsigned DIV_W = 32;
  localparam int unsigned CNT_W = 16;

  localparam logic [1:0] SYNC_ALL0 = 2'h0;
  localparam logic [1:0] SYNC_ALL1 = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WARN_OPEN,
    ST_WARN_CLOSE,
    ST_OPENING,
    ST_CLOSING
  } motion_t;

  typedef struct packed {
    logic stopActive;
    logic openCmd;
    logic closeCmd;
    logic openLimit;
    logic closedLimit;
    logic safetyBar;
  } gate_in_t;

  typedef struct packed {
    logic openContactor;
    logic closeContactor;
    logic warnLamp;
    logic remoteGateOpenStatus;
    logic remoteGateClosedStatus;
  } gate_out_t;

endpackage

// >>> hdl/industrial_gate_controller.sv
// Function
// - start only if not moving opposite way
// - stop input or direction limit ends travel
// - travel interruptible at any moment
// - safety bar withholds closing contactor
// - enhanced: safety bar while closing reopens
// - lamp blinks 5 s before and during travel
// - central variant: travel runs to end unless bar hit while closing
// - central: pull-cord and local switches equal
// - remote requests act like local requests
// - report fully open and fully closed
// - stop, limits, bar normally closed contacts
`timescale 1ns/1ns
`default_nettype none

module industrial_gate_controller
#(
  parameter int unsigned TICK_DIV_P   = gate_pkg::TICK_DIV,
  parameter int unsigned PREWARN_P    = gate_pkg::PREWARN_TICKS,
  parameter int unsigned BLINK_P      = gate_pkg::BLINK_TICKS,
  parameter bit          ENHANCED     = 1'b1,
  parameter bit          CENTRAL      = 1'b0
)
(
  input  wire logic                clk,
  input  wire logic                rst,
  // raw pins, contact sense as wired
  input  wire logic                stopContactNc,
  input  wire logic                openCmdNo,
  input  wire logic                closeCmdNo,
  input  wire logic                pullcordOpenNo,
  input  wire logic                pullcordCloseNo,
  input  wire logic                openLimitNc,
  input  wire logic                closedLimitNc,
  input  wire logic                safetyBarNc,
  input  wire logic                remoteOpenRequest,
  input  wire logic                remoteCloseRequest,
  output gate_pkg::gate_out_t      gateOut
);
  import gate_pkg::*;

  // bit positions of the pins in the synchroniser chain, first pin on top
  localparam int unsigned NPIN           = 10;
  localparam int unsigned PIN_STOP       = 9;
  localparam int unsigned PIN_OPEN       = 8;
  localparam int unsigned PIN_CLOSE      = 7;
  localparam int unsigned PIN_CORD_OPEN  = 6;
  localparam int unsigned PIN_CORD_CLOSE = 5;
  localparam int unsigned PIN_OPEN_LIM   = 4;
  localparam int unsigned PIN_SHUT_LIM   = 3;
  localparam int unsigned PIN_BAR        = 2;
  localparam int unsigned PIN_REM_OPEN   = 1;
  localparam int unsigned PIN_REM_CLOSE  = 0;

  // whole state in one word: synchroniser stages, settled levels,
  // time base, counters, motion state and the registered outputs,
  // so that reset clears all of it in one place
  typedef struct packed {
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
    logic [NPIN-1:0] level;
    logic [DIV_W-1:0] div;
    logic             tick;
    logic [CNT_W-1:0] warnCnt;
    logic [CNT_W-1:0] blinkCnt;
    logic             blink;
    motion_t          motion;
    gate_out_t        out;
  } state_t;

  state_t cur;
  state_t nxt;

  function automatic logic [CNT_W-1:0] asCnt(input int unsigned v);
    asCnt = v[CNT_W-1:0];
  endfunction

  // a pin level moves only when the last two stages agree, so a single
  // unsettled sample in stage one never reaches the state machine
  function automatic logic settle(input logic s2, input logic s3, input logic old);
    if ({s2, s3} == SYNC_ALL1)
    begin
      settle = 1'b1;
    end
    else if ({s2, s3} == SYNC_ALL0)
    begin
      settle = 1'b0;
    end
    else
    begin
      settle = old;
    end
  endfunction

  // true in either pre-warning state
  function automatic logic inWarning(input motion_t m);
    inWarning = (m == ST_WARN_OPEN) || (m == ST_WARN_CLOSE);
  endfunction

  // true while a contactor may be requested
  function automatic logic inTravel(input motion_t m);
    inTravel = (m == ST_OPENING) || (m == ST_CLOSING);
  endfunction

  gate_in_t in;
  logic     openReq;
  logic     closeReq;
  logic     moving;
  logic     warning;

  always_comb
  begin
    // pin order packs ten inputs for the synchroniser chain
    logic [NPIN-1:0] pins;
    pins = {stopContactNc, openCmdNo, closeCmdNo, pullcordOpenNo, pullcordCloseNo,
            openLimitNc, closedLimitNc, safetyBarNc, remoteOpenRequest, remoteCloseRequest};
    nxt = cur;
    nxt.s1 = pins;
    nxt.s2 = cur.s1;
    nxt.s3 = cur.s2;
    // a level changes only once stages two and three agree
    for (int i = 0; i < NPIN; i++)
    begin
      nxt.level[i] = settle(cur.s2[i], cur.s3[i], cur.level[i]);
    end

    // one shared tick keeps every delay in whole ticks; the phase of the
    // first tick may shorten a delay by up to one tick
    // prescaled time tick
    if (cur.div >= TICK_DIV_P[DIV_W-1:0] - 1'b1)
    begin
      nxt.div  = '0;
      nxt.tick = 1'b1;
    end
    else
    begin
      nxt.div  = cur.div + 1'b1;
      nxt.tick = 1'b0;
    end

    // normally closed contacts read active when open
    // a broken wire then reads as stop, limit or bar, the safe side
    in.stopActive  = ~cur.level[PIN_STOP];
    in.openLimit   = ~cur.level[PIN_OPEN_LIM];
    in.closedLimit = ~cur.level[PIN_SHUT_LIM];
    in.safetyBar   = ~cur.level[PIN_BAR];
    // normally open commands read active when closed
    // pull-cord and local switches merged only in the central variant
    in.openCmd  = cur.level[PIN_OPEN] | (CENTRAL & cur.level[PIN_CORD_OPEN])
                | cur.level[PIN_REM_OPEN];
    in.closeCmd = cur.level[PIN_CLOSE] | (CENTRAL & cur.level[PIN_CORD_CLOSE])
                | cur.level[PIN_REM_CLOSE];
    openReq  = in.openCmd & ~in.openLimit;
    closeReq = in.closeCmd & ~in.closedLimit & ~in.safetyBar;

    // central variant ignores the stop input
    // interruption allowed in every moving state
    case (cur.motion)
      ST_IDLE:
      begin
        if (!in.stopActive || CENTRAL)
        begin
          // open wins when both directions are asked at once
          if (openReq)
          begin
            nxt.motion = ST_WARN_OPEN;
          end
          else if (closeReq)
          begin
            nxt.motion = ST_WARN_CLOSE;
          end
        end
      end
      ST_WARN_OPEN:
      begin
        if (in.stopActive && !CENTRAL)
        begin
          nxt.motion = ST_IDLE;
        end
        else if (in.openLimit)
        begin
          nxt.motion = ST_IDLE;
        end
        else if (cur.warnCnt >= asCnt(PREWARN_P))
        begin
          nxt.motion = ST_OPENING;
        end
      end
      ST_WARN_CLOSE:
      begin
        if (in.stopActive && !CENTRAL)
        begin
          nxt.motion = ST_IDLE;
        end
        else if (in.closedLimit)
        begin
          nxt.motion = ST_IDLE;
        end
        else if (in.safetyBar)
        begin
          nxt.motion = ENHANCED ? ST_WARN_OPEN : ST_IDLE;
        end
        else if (cur.warnCnt >= asCnt(PREWARN_P))
        begin
          nxt.motion = ST_CLOSING;
        end
      end
      ST_OPENING:
      begin
        if ((in.stopActive && !CENTRAL) || in.openLimit)
        begin
          nxt.motion = ST_IDLE;
        end
      end
      ST_CLOSING:
      begin
        // bar while closing reverses with a fresh warning
        if (in.safetyBar)
        begin
          nxt.motion = ENHANCED ? ST_WARN_OPEN : ST_IDLE;
        end
        else if ((in.stopActive && !CENTRAL) || in.closedLimit)
        begin
          nxt.motion = ST_IDLE;
        end
      end
      default:
      begin
        nxt.motion = ST_IDLE;
      end
    endcase

    warning = inWarning(nxt.motion);
    moving  = inTravel(nxt.motion);

    // warning count restarts on every entry into a warning state
    if (nxt.motion != cur.motion)
    begin
      nxt.warnCnt = '0;
    end
    else if (warning && cur.tick && cur.warnCnt < asCnt(PREWARN_P))
    begin
      nxt.warnCnt = cur.warnCnt + 1'b1;
    end

    // lamp flashes through warning and travel
    if (!(warning || moving))
    begin
      nxt.blinkCnt = '0;
      nxt.blink    = 1'b0;
    end
    else if (cur.tick)
    begin
      if (cur.blinkCnt >= asCnt(BLINK_P) - 1'b1)
      begin
        nxt.blinkCnt = '0;
        nxt.blink    = ~cur.blink;
      end
      else
      begin
        nxt.blinkCnt = cur.blinkCnt + 1'b1;
      end
    end
    // lamp lights at once on leaving idle, so the first flash is never late
    if ((warning || moving) && (cur.motion == ST_IDLE))
    begin
      nxt.blink = 1'b1;
    end

    // outputs follow the next state, so they change on the state's own edge
    // only one contactor from a single state
    nxt.out.openContactor  = (nxt.motion == ST_OPENING);
    nxt.out.closeContactor = (nxt.motion == ST_CLOSING) && !in.safetyBar;
    nxt.out.warnLamp       = nxt.blink;
    // end positions reported to the remote master
    nxt.out.remoteGateOpenStatus   = in.openLimit;
    nxt.out.remoteGateClosedStatus = in.closedLimit;

    // reset also empties the synchroniser, so pins are re-learned afterwards
    if (rst)
    begin
      nxt = '0;
      nxt.motion = ST_IDLE;
    end
  end

  // one register stage holds the whole state
  always_ff @(posedge clk)
  begin
    cur <= nxt;
  end

  assign gateOut = cur.out;

endmodule

`default_nettype wire

// >>> verification/gate_partner.sv
`timescale 1ns/1ns
`default_nettype none
module gate_partner
  import gate_pkg::*;
#(
  parameter int TRAVEL = 60
)
(
  input  wire gate_out_t gateOut,
  input  wire logic      clk,
  output logic           openLimitNc,
  output logic           closedLimitNc
);
  // gate starts fully closed
  int pos = 0;
  always @(negedge clk)
  begin
    if (gateOut.openContactor && pos < TRAVEL)
      pos <= pos + 1;
    else if (gateOut.closeContactor && pos > 0)
      pos <= pos - 1;
  end
  assign openLimitNc   = (pos != TRAVEL);
  assign closedLimitNc = (pos != 0);
endmodule
`default_nettype wire

// >>> verification/industrial_gate_controller_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module gate_checker
  import gate_pkg::*;
#(
  parameter int unsigned PREWARN_P  = 5,
  parameter int unsigned TICK_DIV_P = 4
)
(
  input wire logic      clk,
  input wire logic      rst,
  input wire logic      stopContactNc,
  input wire logic      openLimitNc,
  input wire logic      closedLimitNc,
  input wire logic      safetyBarNc,
  input wire gate_out_t gateOut
);
  logic [15:0] idle;
  wire logic   moving = |gateOut[4:3];
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence barDown; !safetyBarNc [*8]; endsequence
  // idle cycles since a contactor was last on; tick phase may cut one tick
  always_ff @(posedge clk)
    idle <= (rst || moving) ? 16'h0000 : idle + 16'h0001;
  contactor_excl_a: assert property (gateOut[4:3] != 2'h3) else $error("both on");
  bar_holds_close_a: assert property (barDown |-> !gateOut[3]) else $error("bar");
  open_limit_stop_a: assert property (!openLimitNc [*8] |-> !gateOut[4]) else $error("ol");
  shut_limit_stop_a: assert property (!closedLimitNc [*8] |-> !gateOut[3]) else $error("cl");
  stop_ends_a: assert property (!stopContactNc [*8] |-> !moving) else $error("stop");
  open_status_a: assert property ($stable(openLimitNc) [*8] |-> gateOut[1] == !openLimitNc)
    else $error("open status");
  shut_status_a: assert property ($stable(closedLimitNc) [*8] |-> gateOut[0] == !closedLimitNc)
    else $error("closed status");
  prewarn_time_a: assert property ($rose(moving) |-> idle >= (PREWARN_P - 1) * TICK_DIV_P)
    else $error("short warning");
endmodule
bind industrial_gate_controller gate_checker #(.PREWARN_P(PREWARN_P), .TICK_DIV_P(TICK_DIV_P))
  gate_checker_inst (.clk(clk), .rst(rst), .stopContactNc(stopContactNc),
  .openLimitNc(openLimitNc), .closedLimitNc(closedLimitNc), .safetyBarNc(safetyBarNc),
  .gateOut(gateOut));
`default_nettype wire

// >>> verification/test_industrial_gate_controller.sv
`timescale 1ns/1ns
`default_nettype none
module test_industrial_gate_controller;
  import gate_pkg::*;
  logic      clk = 0, rst = 1, stopNc = 1, openCmd = 0, closeCmd = 0, barNc = 1;
  logic      remOpen = 0, remClose = 0, openLimitNc, closedLimitNc;
  gate_out_t gateOut;
  int        failCount = 0, checkCount = 0, n;
  initial forever #5 clk = ~clk;
  industrial_gate_controller #(.TICK_DIV_P(4), .PREWARN_P(5), .BLINK_P(2))
    industrial_gate_controller_inst (.clk(clk), .rst(rst), .stopContactNc(stopNc),
    .openCmdNo(openCmd), .closeCmdNo(closeCmd), .pullcordOpenNo(1'b0), .pullcordCloseNo(1'b0),
    .openLimitNc(openLimitNc), .closedLimitNc(closedLimitNc), .safetyBarNc(barNc),
    .remoteOpenRequest(remOpen), .remoteCloseRequest(remClose), .gateOut(gateOut));
  gate_partner gate_partner_inst (.gateOut(gateOut), .clk(clk), .openLimitNc(openLimitNc),
    .closedLimitNc(closedLimitNc));
  task automatic finishTest();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      failCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded wait; n gives cycles spent
  task automatic waitOut(input int b, input logic v);
    n = 0;
    while (gateOut[b] !== v && n < 400)
    begin
      cyc(1);
      n++;
    end
    if (n == 400)
    begin
      failCount++;
      finishTest();
    end
  endtask
  task automatic openTest();
    logic [1:0] lampSeen;
    remOpen = 1;
    cyc(10);
    remOpen = 0;
    waitOut(4, 1);
    chk(5'(n >= 11), 5'h01);
    // lamp must show both levels while the gate travels
    lampSeen = 2'h0;
    repeat (20)
    begin
      cyc(1);
      lampSeen = lampSeen | (gateOut.warnLamp ? 2'h2 : 2'h1);
    end
    chk(5'(lampSeen), 5'h03);
    waitOut(4, 0);
    cyc(8);
    chk(gateOut, 5'h02);
    $display("open done");
  endtask
  task automatic barTest();
    closeCmd = 1;
    cyc(10);
    closeCmd = 0;
    waitOut(3, 1);
    cyc(5);
    barNc = 0;
    waitOut(4, 1);
    barNc = 1;
    waitOut(4, 0);
    cyc(8);
    chk(gateOut, 5'h02);
    $display("bar done");
  endtask
  task automatic stopTest();
    remClose = 1;
    cyc(10);
    remClose = 0;
    waitOut(3, 1);
    cyc(5);
    stopNc = 0;
    cyc(8);
    chk(gateOut, 5'h00);
    stopNc = 1;
    cyc(8);
    $display("stop done");
  endtask
  task automatic oppTest();
    remClose = 1;
    cyc(10);
    remClose = 0;
    waitOut(3, 1);
    openCmd = 1;
    cyc(20);
    chk(5'(gateOut[4:3]), 5'h01);
    openCmd = 0;
    waitOut(3, 0);
    cyc(8);
    chk(gateOut, 5'h01);
    $display("opposite done");
  endtask
  initial
  begin
    cyc(6);
    chk(gateOut, 5'h00);
    rst = 0;
    openTest();
    barTest();
    stopTest();
    oppTest();
    finishTest();
  end
endmodule
`default_nettype wire
